/* File: atpo_override.sv */
/*
   Auto-tuning parameter override: holds host-written and effective control
   parameters apart, forces fixed values while tuning and gain-switching values
   while tuning at standstill, masks observer enables, applies stiffness gains at standstill and paces
   saves of estimated results to non-volatile memory.
   Assumes host strobes and estimator outputs are synchronous to sys_clk_in;
   the non-volatile store acknowledges nothing and takes one-cycle pulses.
*/
`timescale 1ns/100ps
module atpo_override
#(
   parameter int     W          = atpo_pkg::PARAM_W,
   parameter longint SAVE_CYCLES = atpo_pkg::SAVE_CYCLES
)
(
   // Clock and reset.
   input  wire logic          sys_clk_in,
   input  wire logic          rst_in,
   // Host parameter settings.
   input  wire logic [3:0]    autotune_mode_sel_in,
   input  wire logic [4:0]    machine_stiffness_level_in,
   input  wire logic          fixed_param_en_in,
   input  wire logic          gain_switch_en_in,
   input  wire logic          keep_current_in,
   input  wire logic [W-1:0]  function_expansion_word_in,
   input  wire logic [W-1:0]  dist_comp_gain_in,
   input  wire logic [W-1:0]  dist_observer_filter_in,
   input  wire logic [W-1:0]  host_ff_in [4],
   input  wire logic [W-1:0]  host_vd_in [2],
   input  wire logic [W-1:0]  host_sw_in [14],
   input  wire logic [W-1:0]  host_gain_in [8],
   // Motor state and estimator results.
   input  wire logic          servo_on_in,
   input  wire logic          motor_stopped_in,
   input  wire logic          estimate_valid_in,
   input  wire logic [W-1:0]  est_result_in [4],
   // Non-volatile memory.
   input  wire logic          nv_loaded_in,
   input  wire logic [W-1:0]  nv_result_in [4],
   output logic               nv_save_out,
   output logic [W-1:0]       nv_data_out [4],
   // Effective values to control.
   output logic [W-1:0]       eff_vd_out [2],
   output logic [W-1:0]       eff_ff_out [4],
   output logic [W-1:0]       eff_sw_out [14],
   output logic [W-1:0]       eff_gain_out [8],
   output logic [W-1:0]       eff_expansion_out,
   output logic               dist_observer_on_out,
   output logic [W-1:0]       result_out [4],
   output logic [4:0]         applied_stiffness_out
);
   atpo_pkg::atpo_state_type state;
   logic [W-1:0]             next_sw [14];
   logic [W-1:0]             tbl [atpo_pkg::STIFF_LEVELS][8];
   logic [63:0]              save_cnt;
   logic                     tuning;

   // A nonzero mode selection is the only enable; host clears it to stop.
   assign tuning = (autotune_mode_sel_in != 4'h0);

   // Gain table per stiffness level, columns: 1st pos, vel, int, trq, 2nd pos (own value), vel and trq as 1st, int fixed 10000.
   function automatic logic [W-1:0] row_val(input int p, input int v, input int i,
                                            input int t, input int p2, input int c);
      int r;
      case (c)
         0: r = p;
         1: r = v;
         2: r = i;
         3: r = t;
         4: r = p2;
         5: r = v;
         6: r = 10000;
         default: r = t;
      endcase
      return W'(r);
   endfunction

   // Constant lookup, built once as combinational wiring.
   always_comb
   begin
      for (int c = 0; c < 8; c++)
      begin
         tbl[0][c]  = row_val(20, 15, 3700, 1500, 25, c);
         tbl[1][c]  = row_val(25, 20, 2800, 1100, 30, c);
         tbl[2][c]  = row_val(30, 25, 2200, 900, 40, c);
         tbl[3][c]  = row_val(40, 30, 1900, 800, 45, c);
         tbl[4][c]  = row_val(45, 35, 1600, 600, 55, c);
         tbl[5][c]  = row_val(55, 45, 1200, 500, 70, c);
         tbl[6][c]  = row_val(75, 60, 900, 400, 95, c);
         tbl[7][c]  = row_val(95, 75, 700, 300, 120, c);
         tbl[8][c]  = row_val(115, 90, 600, 300, 140, c);
         tbl[9][c]  = row_val(140, 110, 500, 200, 175, c);
         tbl[10][c] = row_val(175, 140, 400, 200, 220, c);
         tbl[11][c] = row_val(320, 180, 310, 126, 380, c);
         tbl[12][c] = row_val(390, 220, 250, 103, 460, c);
         tbl[13][c] = row_val(480, 270, 210, 84, 570, c);
         tbl[14][c] = row_val(630, 350, 160, 65, 730, c);
         tbl[15][c] = row_val(720, 400, 140, 57, 840, c);
         tbl[16][c] = row_val(900, 500, 120, 45, 1050, c);
         tbl[17][c] = row_val(1080, 600, 110, 38, 1260, c);
         tbl[18][c] = row_val(1350, 750, 90, 30, 1570, c);
         tbl[19][c] = row_val(1620, 900, 80, 25, 1880, c);
         tbl[20][c] = row_val(2060, 1150, 70, 20, 2410, c);
         tbl[21][c] = row_val(2510, 1400, 60, 16, 2930, c);
         tbl[22][c] = row_val(3050, 1700, 50, 13, 3560, c);
         tbl[23][c] = row_val(3770, 2100, 40, 11, 4400, c);
         tbl[24][c] = row_val(4490, 2500, 40, 9, 5240, c);
         tbl[25][c] = row_val(5000, 2800, 35, 8, 5900, c);
         tbl[26][c] = row_val(5600, 3100, 30, 7, 6500, c);
         tbl[27][c] = row_val(6100, 3400, 30, 7, 7100, c);
         tbl[28][c] = row_val(6600, 3700, 25, 6, 7700, c);
         tbl[29][c] = row_val(7200, 4000, 25, 6, 8400, c);
         tbl[30][c] = row_val(8100, 4500, 20, 5, 9400, c);
         tbl[31][c] = row_val(9000, 5000, 20, 5, 10500, c);
      end
   end

   // Gain-switching values; host copy passes through, except while tuning: the position switching mode is forced, and the rest too unless the setting is kept.
   always_comb
   begin
      for (int k = 0; k < 14; k++)
      begin
         next_sw[k] = host_sw_in[k];
      end
      if (tuning)
      begin
         next_sw[1] = gain_switch_en_in ? atpo_pkg::POS_SW_MODE_ON
                                        : atpo_pkg::POS_SW_MODE_OFF;
         if (!keep_current_in)
         begin
            next_sw[0] = atpo_pkg::SECOND_GAIN_ON;
            next_sw[2] = atpo_pkg::POS_SW_DLY_LVL;
            next_sw[3] = atpo_pkg::POS_SW_DLY_LVL;
            next_sw[4] = atpo_pkg::POS_SW_HYS_TIME;
            next_sw[5] = atpo_pkg::POS_SW_HYS_TIME;
            for (int k = 6; k < 14; k++)
            begin
               next_sw[k] = atpo_pkg::VT_SW_CLEAR;
            end
         end
      end
   end

   // Sequencer: wait for the stored results, then run the tuning loop.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
         state <= atpo_pkg::ATPO_IDLE;
      else
      begin
         case (state)
            atpo_pkg::ATPO_IDLE: if (nv_loaded_in) state <= atpo_pkg::ATPO_LOAD;
            atpo_pkg::ATPO_LOAD: state <= atpo_pkg::ATPO_RUN;
            atpo_pkg::ATPO_RUN:  state <= atpo_pkg::ATPO_RUN;
            default:             state <= atpo_pkg::ATPO_IDLE;
         endcase
      end
   end

   // Estimated results: seeded from storage, then refined while servo is on.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int k = 0; k < 4; k++)
         begin
            result_out[k] <= atpo_pkg::ZERO16;
         end
      end
      else if (state == atpo_pkg::ATPO_LOAD)
      begin
         for (int k = 0; k < 4; k++)
         begin
            result_out[k] <= nv_result_in[k];
         end
      end
      else if (state == atpo_pkg::ATPO_RUN && tuning && servo_on_in && estimate_valid_in)
      begin
         for (int k = 0; k < 4; k++)
         begin
            result_out[k] <= est_result_in[k];
         end
      end
   end

   // Save timer; anything estimated after the last save is lost at power-off.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         save_cnt    <= 64'h0;
         nv_save_out <= 1'b0;
         for (int k = 0; k < 4; k++)
         begin
            nv_data_out[k] <= atpo_pkg::ZERO16;
         end
      end
      else
      begin
         nv_save_out <= 1'b0;
         if (state != atpo_pkg::ATPO_RUN)
            save_cnt <= 64'h0;
         else if (save_cnt == 64'(SAVE_CYCLES - 1))
         begin
            save_cnt    <= 64'h0;
            nv_save_out <= 1'b1;
            // The snapshot is the result as it stood before this edge.
            for (int k = 0; k < 4; k++)
            begin
               nv_data_out[k] <= result_out[k];
            end
         end
         else
            save_cnt <= save_cnt + 64'h1;
      end
   end

   // Gains change only at standstill so a running axis never sees a step.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         applied_stiffness_out <= 5'h00;
         for (int k = 0; k < 8; k++) eff_gain_out[k] <= atpo_pkg::ZERO16;
         for (int k = 0; k < 14; k++) eff_sw_out[k] <= atpo_pkg::ZERO16;
      end
      else if (motor_stopped_in)
      begin
         applied_stiffness_out <= machine_stiffness_level_in;
         for (int k = 0; k < 8; k++)
            eff_gain_out[k] <= tuning ? tbl[machine_stiffness_level_in][k]
                                      : host_gain_in[k];
         for (int k = 0; k < 14; k++) eff_sw_out[k] <= next_sw[k];
      end
   end

   // Fixed-parameter overrides; host values untouched in their own ports.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int k = 0; k < 2; k++) eff_vd_out[k] <= atpo_pkg::ZERO16;
         for (int k = 0; k < 4; k++) eff_ff_out[k] <= atpo_pkg::ZERO16;
      end
      else if (tuning && fixed_param_en_in)
      begin
         eff_vd_out[0] <= atpo_pkg::VEL_DET_FORCED;
         eff_vd_out[1] <= atpo_pkg::VEL_DET_FORCED;
         eff_ff_out[0] <= atpo_pkg::VEL_FF_GAIN_FIX;
         eff_ff_out[1] <= atpo_pkg::VEL_FF_FILT_FIX;
         eff_ff_out[2] <= atpo_pkg::TRQ_FF_FIX;
         eff_ff_out[3] <= atpo_pkg::TRQ_FF_FIX;
      end
      else
      begin
         for (int k = 0; k < 2; k++) eff_vd_out[k] <= host_vd_in[k];
         for (int k = 0; k < 4; k++) eff_ff_out[k] <= host_ff_in[k];
      end
   end

   // Observer masking acts on the effective copy of the expansion word and on dist_observer_on_out, never on the host word.
   always_ff @(posedge sys_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         eff_expansion_out    <= atpo_pkg::ZERO16;
         dist_observer_on_out <= 1'b0;
      end
      else
      begin
         eff_expansion_out <= function_expansion_word_in;
         if (tuning)
         begin
            eff_expansion_out[atpo_pkg::INST_OBS_BIT] <= 1'b0;
            eff_expansion_out[atpo_pkg::DIST_OBS_BIT] <= 1'b0;
         end
         // The compensating gain and observer filter are kept by the host only.
         // Nothing here reads them, so a write to either never wakes the observer.
         // Gain and filter inputs stay free to change; they cannot re-enable it.
         dist_observer_on_out <= !tuning
                                 && function_expansion_word_in[atpo_pkg::DIST_OBS_BIT];
      end
   end
endmodule

/* File: atpo_pkg.sv */
/*
   Constants for the auto-tuning parameter override block: forced values,
   gain-switching defaults, field positions, widths and save timing.
   Assumes a single 10 MHz system clock.
*/
package atpo_pkg;
   localparam int                 PARAM_W          = 16;
   localparam int                 CLK_HZ           = 10000000;
   localparam int                 SAVE_MINUTES     = 30;
   localparam longint             SAVE_CYCLES      = longint'(SAVE_MINUTES) * 60 * CLK_HZ;
   localparam logic [15:0]        VEL_DET_FORCED   = 16'h0000;
   localparam logic [15:0]        VEL_FF_GAIN_FIX  = 16'h012C;
   localparam logic [15:0]        VEL_FF_FILT_FIX  = 16'h0032;
   localparam logic [15:0]        TRQ_FF_FIX       = 16'h0000;
   localparam logic [15:0]        SECOND_GAIN_ON   = 16'h0001;
   localparam logic [15:0]        POS_SW_MODE_ON   = 16'h000A;
   localparam logic [15:0]        POS_SW_MODE_OFF  = 16'h0000;
   localparam logic [15:0]        POS_SW_DLY_LVL   = 16'h0032;
   localparam logic [15:0]        POS_SW_HYS_TIME  = 16'h0021;
   localparam logic [15:0]        VT_SW_CLEAR      = 16'h0000;
   localparam int                 INST_OBS_BIT     = 0;
   localparam int                 DIST_OBS_BIT     = 1;
   localparam int                 STIFF_LEVELS     = 32;
   localparam logic [15:0]        ZERO16           = 16'h0000;

   typedef enum logic [1:0]
   {
      ATPO_IDLE   = 2'b00,
      ATPO_LOAD   = 2'b01,
      ATPO_RUN    = 2'b10
   } atpo_state_type;
endpackage

/* File: atpo_override_props.sv */
/*
   Port checker for the tuning override block.
   Assumes one clock domain and the active-high asynchronous reset.
*/
`timescale 1ns/100ps
module atpo_override_props
(
   // Clock, reset and settings.
   input wire logic        sys_clk_in,
   input wire logic        rst_in,
   input wire logic [3:0]  autotune_mode_sel_in,
   input wire logic [4:0]  machine_stiffness_level_in,
   input wire logic        fixed_param_en_in,
   input wire logic        gain_switch_en_in,
   input wire logic        keep_current_in,
   input wire logic        motor_stopped_in,
   input wire logic        nv_loaded_in,
   input wire logic [15:0] nv_result_in [4],
   // Watched outputs.
   input wire logic [15:0] eff_vd_out [2],
   input wire logic [15:0] eff_ff_out [4],
   input wire logic [15:0] eff_sw_out [14],
   input wire logic        dist_observer_on_out,
   input wire logic        nv_save_out,
   input wire logic [15:0] nv_data_out [4],
   input wire logic [15:0] result_out [4],
   input wire logic [4:0]  applied_stiffness_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // Qualifiers shared by the checks below.
   wire logic tune = autotune_mode_sel_in != 4'h0;
   wire logic fix  = tune && fixed_param_en_in;
   wire logic stp  = tune && motor_stopped_in;
   // A restore takes two edges, so it is split into request and landing.
   sequence s_load_req;
      $rose(nv_loaded_in);
   endsequence
   sequence s_load_done;
      ##2 result_out[0] == $past(nv_result_in[0], 1);
   endsequence
   a_vd_forced: assert property (fix |=> eff_vd_out[0] == 16'h0000 && eff_vd_out[1] == 16'h0000)
      else $error("velocity detect filter not forced");
   a_vff_gain: assert property (fix |=> eff_ff_out[0] == 16'h012C)
      else $error("velocity feed forward gain wrong");
   a_vff_filt: assert property (fix |=> eff_ff_out[1] == 16'h0032)
      else $error("velocity feed forward filter wrong");
   a_tff_clear: assert property (fix |=> eff_ff_out[2] == 16'h0000 && eff_ff_out[3] == 16'h0000)
      else $error("torque feed forward not cleared");
   a_pos_mode: assert property (stp && gain_switch_en_in |=> eff_sw_out[1] == 16'h000A)
      else $error("position switching mode not ten");
   a_sw_defaults: assert property (stp && !keep_current_in |=> eff_sw_out[2] == 16'h0032 && eff_sw_out[4] == 16'h0021)
      else $error("switching defaults wrong");
   a_pos_mode_off: assert property (stp && !gain_switch_en_in |=> eff_sw_out[1] == 16'h0000)
      else $error("position switching mode not zero");
   a_second_gain: assert property (stp && !keep_current_in |=> eff_sw_out[0] == 16'h0001)
      else $error("second gain enable not set");
   a_vt_cleared: assert property (stp && !keep_current_in |=> eff_sw_out[6] == 16'h0000 && eff_sw_out[9] == 16'h0000 && eff_sw_out[10] == 16'h0000 && eff_sw_out[13] == 16'h0000)
      else $error("velocity or torque switching not cleared");
   a_obs_masked: assert property (tune |=> !dist_observer_on_out)
      else $error("observer enabled while tuning");
   a_stiff_hold: assert property (!motor_stopped_in |=> $stable(applied_stiffness_out))
      else $error("stiffness applied while moving");
   a_stiff_apply: assert property (stp |=> applied_stiffness_out == $past(machine_stiffness_level_in))
      else $error("stiffness not applied at standstill");
   a_nv_restore: assert property (s_load_req |-> s_load_done)
      else $error("stored result not restored");
   a_save_data: assert property (nv_save_out |-> nv_data_out[0] == $past(result_out[0]))
      else $error("saved data differs from result");
endmodule

/* File: atpo_override_bench.sv */
/*
   Self-checking bench for the tuning override block.
   Assumes the design's registered outputs and a shortened save interval.
*/
`timescale 1ns/100ps
module atpo_override_bench;
   logic        sys_clk_in, rst_in, fix, gsw, keep, servo, stopped, est_v, nv_ld;
   logic [3:0]  mode;
   logic [4:0]  stiff, appl;
   logic [15:0] exp_w, dcg, dof, eff_exp;
   logic [15:0] hff [4], hvd [2], hsw [14], hg [8], est [4], nvr [4], nvd [4];
   logic [15:0] evd [2], eff [4], esw [14], egn [8], res [4];
   logic        save, obs;
   int          err_count, checks_done;
   // Expected switching values and level 31 gains.
   logic [15:0] sw_e [14] = '{16'h0001, 16'h000A, 16'h0032, 16'h0032, 16'h0021, 16'h0021,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
   logic [15:0] g31 [8] = '{16'h2328, 16'h1388, 16'h0014, 16'h0005, 16'h2904, 16'h1388,
      16'h2710, 16'h0005};
   atpo_override #(.SAVE_CYCLES(20)) DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .autotune_mode_sel_in(mode), .machine_stiffness_level_in(stiff), .fixed_param_en_in(fix),
      .gain_switch_en_in(gsw), .keep_current_in(keep), .function_expansion_word_in(exp_w),
      .dist_comp_gain_in(dcg), .dist_observer_filter_in(dof), .host_ff_in(hff), .host_vd_in(hvd),
      .host_sw_in(hsw), .host_gain_in(hg), .servo_on_in(servo), .motor_stopped_in(stopped),
      .estimate_valid_in(est_v), .est_result_in(est), .nv_loaded_in(nv_ld), .nv_result_in(nvr),
      .nv_save_out(save), .nv_data_out(nvd), .eff_vd_out(evd), .eff_ff_out(eff),
      .eff_sw_out(esw), .eff_gain_out(egn), .eff_expansion_out(eff_exp),
      .dist_observer_on_out(obs), .result_out(res), .applied_stiffness_out(appl));
   // Free-running 10 MHz clock.
   initial
   begin
      sys_clk_in = 1'b0;
      forever #50 sys_clk_in = ~sys_clk_in;
   end
   // Compares one value; case equality so an unknown never matches.
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   // Inputs change only at falling edges, away from sampling.
   task automatic step(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // The whole run needs well under a thousand cycles.
   initial
   begin
      #200000;
      err_count++;
      test_done();
   end
   // Main sequence.
   initial
   begin
      err_count = 0; checks_done = 0; rst_in = 1'b1; mode = 4'h0; stiff = 5'h00; fix = 1'b0;
      gsw = 1'b0; keep = 1'b0; servo = 1'b0; stopped = 1'b0; est_v = 1'b0; nv_ld = 1'b0;
      exp_w = 16'h0007; dcg = 16'h0010; dof = 16'h0100;
      hff = '{16'h0011, 16'h0022, 16'h0033, 16'h0044}; hvd = '{16'h0003, 16'h0004};
      hg = '{default: 16'h0099}; hsw = '{default: 16'h0077};
      est = '{16'h0A0A, 16'h0B0B, 16'h0C0C, 16'h0D0D};
      nvr = '{16'h0101, 16'h0202, 16'h0303, 16'h0404};
      repeat (20) @(posedge sys_clk_in);
      step(1);
      rst_in = 1'b0;
      fix = 1'b1;
      step(2);
      for (int i = 0; i < 4; i++) chk("ff pass", hff[i], eff[i]);
      chk("observer on", 16'h0001, {15'h0, obs});
      mode = 4'h1; stiff = 5'h1F; gsw = 1'b1; dcg = 16'h0020;
      step(2);
      chk("vd0", 16'h0000, evd[0]);
      chk("vd1", 16'h0000, evd[1]);
      chk("vff gain", 16'h012C, eff[0]);
      chk("vff filt", 16'h0032, eff[1]);
      chk("tff gain", 16'h0000, eff[2]);
      chk("tff filt", 16'h0000, eff[3]);
      chk("observer off", 16'h0000, {15'h0, obs});
      chk("expansion", 16'h0004, eff_exp);
      chk("stiff moving", 16'h0000, {11'h0, appl});
      stopped = 1'b1;
      step(2);
      chk("stiff stopped", 16'h001F, {11'h0, appl});
      for (int i = 0; i < 8; i++) chk("gain", g31[i], egn[i]);
      for (int i = 0; i < 14; i++) chk("switch", sw_e[i], esw[i]);
      gsw = 1'b0; keep = 1'b1;
      step(2);
      chk("pos mode off", 16'h0000, esw[1]);
      chk("kept delay", 16'h0077, esw[2]);
      chk("kept 2nd gain", 16'h0077, esw[0]);
      nv_ld = 1'b1;
      step(1);
      nv_ld = 1'b0;
      step(2);
      for (int i = 0; i < 4; i++) chk("restore", nvr[i], res[i]);
      est_v = 1'b1;
      step(3);
      chk("no servo", 16'h0101, res[0]);
      servo = 1'b1;
      step(2);
      for (int i = 0; i < 4; i++) chk("estimate", est[i], res[i]);
      for (int n = 0; n < 40 && save !== 1'b1; n++) step(1);
      chk("save pulse", 16'h0001, {15'h0, save});
      for (int i = 0; i < 4; i++) chk("save data", est[i], nvd[i]);
      mode = 4'h0;
      step(2);
      chk("observer back", 16'h0001, {15'h0, obs});
      chk("expansion back", 16'h0007, eff_exp);
      chk("gain host", 16'h0099, egn[0]);
      chk("switch host", 16'h0077, esw[1]);
      chk("vd host", hvd[0], evd[0]);
      test_done();
   end
endmodule
bind atpo_override atpo_override_props u_props (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
   .autotune_mode_sel_in(autotune_mode_sel_in),
   .machine_stiffness_level_in(machine_stiffness_level_in),
   .fixed_param_en_in(fixed_param_en_in), .gain_switch_en_in(gain_switch_en_in),
   .keep_current_in(keep_current_in), .motor_stopped_in(motor_stopped_in),
   .nv_loaded_in(nv_loaded_in), .nv_result_in(nv_result_in), .eff_vd_out(eff_vd_out),
   .eff_ff_out(eff_ff_out), .eff_sw_out(eff_sw_out), .dist_observer_on_out(dist_observer_on_out),
   .nv_save_out(nv_save_out), .nv_data_out(nv_data_out), .result_out(result_out),
   .applied_stiffness_out(applied_stiffness_out));
